// File: bench/perb_builder_tb.sv
// self-checking bench for the record builder
module perb_builder_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 0, srst = 1, ten = 0, lv = 0, record_valid;
	logic [2:0] ld = 3'h0;
	logic [7:0] core_tag = 8'h00;
	logic [63:0] ts = 64'h0;
	logic [31:0] sd = 32'hd2833623;
	perb_pkg::perb_retire_s retire;
	perb_pkg::perb_record_s record, q[$];
	int miscompares = 0, checked = 0;
	// load mask and bit, retire flags, expected code
	logic [23:0] steps [9] = '{24'h0c0002,
		24'h4a0000, 24'hdcb402,
		24'h8cb403, 24'h8cc000,
		24'h0c8403, 24'h8c8c03,
		24'h0d0101, 24'h4d0002};
	always #50 mclk = ~mclk;
	perb_pipe perb_pipe_inst (.mclk, .retire);
	perb_builder perb_builder_inst (.mclk, .srst, .retire, .core_tag,
		.timestamp_enable_flag(ten), .perf_timestamp_counter(ts),
		.load_value_cnt(ld[0]), .load_instr_cnt(ld[1]),
		.load_branch_cnt(ld[2]), .load_value({31'h0, lv}), .record,
		.record_valid);
	function automatic logic [31:0] rnd();
		sd = {sd[30:0], ^(sd & 32'h80200003)};
		return sd;
	endfunction
	task automatic check(input logic [255:0] seen, want);
		checked++;
		if (seen !== want) begin
			miscompares++;
			$display("BAD record want %h seen %h", want, seen);
		end
	endtask
	task automatic test_done();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// optional counter load, one retirement, note of its record
	task automatic go(input logic [23:0] s);
		logic [383:0] b;
		perb_pkg::perb_retire_s r;
		perb_pkg::perb_record_s e;
		for (int i = 0; i < 12; i++) b = {b[351:0], rnd()};
		r = {s[19:8], b[303:0]};
		if (s[23:20] != 4'h0) begin
			perb_pipe_inst.send('0);
			{ld, lv} <= s[23:20];
			perb_pipe_inst.send('0);
			ld <= 3'h0;
		end
		perb_pipe_inst.send(r);
		{core_tag, ten, ts} <= b[383:311];
		e = {b[375] ? b[374:311] : 64'h0, 176'h0, b[383:376], s[7:0]};
		e.addr = r.fused ? r.cond_addr : r.instr_addr;
		if (s[1:0] == 2'h3) begin
			e.data2 = r.next_addr;
			e.flags[15:12] = {r.taken | r.unconditional, r.pred_valid
				& (r.pred_ok | r.unconditional), r.pred_valid, r.fused};
		end
		if (s[1:0] == 2'h1) begin
			e.flags = r.imm;
			e.data1 = r.rm_value;
			e.data2 = r.legacy_mode ? 64'(r.reg_value[31:0]) : r.reg_value;
		end
		if (s[1:0] != 2'h0) q.push_back(e);
	endtask
	// compare each raised record with the oldest note
	always @(posedge mclk) begin
		if (record_valid === 1'b1) begin
			check(record, q.size() ? q.pop_front() : 'x);
		end
	end
	initial begin
		repeat (3) @(posedge mclk);
		srst <= 1'b0;
		foreach (steps[i]) go(steps[i]);
		perb_pipe_inst.send('0);
		repeat (4) @(posedge mclk);
		check(256'(q.size()), 256'h0);
		test_done();
	end
	// cut a hang short
	initial begin
		#20000;
		miscompares++;
		test_done();
	end
endmodule

// File: bench/perb_monitor.sv
// port assertions for the record builder
module perb_monitor (
	input wire logic mclk,
	input wire logic srst,
	input wire perb_pkg::perb_retire_s retire,
	input wire logic [7:0] core_tag,
	input wire perb_pkg::perb_record_s record,
	input wire logic record_valid
);
	timeunit 1ns;
	timeprecision 1ns;
	wire v = record_valid;
	wire [7:0] ec = record.event_type_code;
	default clocking @(posedge mclk);
	endclocking
	default disable iff (srst);
	// record timing, codes and copied fields
	a_valid_cause: assert property (v |-> $past(retire.valid, 2))
		else $error("stray");
	a_code_ok: assert property (v |-> ec inside {[8'h01:8'h03]})
		else $error("code");
	a_tag_copy: assert property (v |->
		record.core_tag == $past(core_tag, 2))
		else $error("tag");
	a_instr_zero: assert property (v && ec == 8'h02 |-> !record.data2)
		else $error("zero");
	a_br_target: assert property (v && ec == 8'h03 |->
		record.data2 == $past(retire.next_addr, 2))
		else $error("target");
	a_br_taken: assert property (v && ec == 8'h03
		&& $past(retire.unconditional, 2) |-> record.flags[15])
		else $error("taken");
	a_val_imm: assert property (v && ec == 8'h01
		|-> record.flags == $past(retire.imm, 2))
		else $error("imm");
	a_val_addr: assert property (v && ec == 8'h01
		|-> record.addr == $past(retire.instr_addr, 2))
		else $error("addr");
	// main record kinds
	c_value: cover property (v && ec == 8'h01);
	c_instr: cover property (v && ec == 8'h02);
	c_branch: cover property (v && ec == 8'h03);
endmodule
bind perb_builder perb_monitor perb_monitor_inst (.mclk, .srst, .retire,
	.core_tag, .record, .record_valid);

// File: bench/perb_pipe.sv
// retirement pipeline stand-in
module perb_pipe (
	input wire logic mclk,
	output perb_pkg::perb_retire_s retire
);
	timeunit 1ns;
	timeprecision 1ns;
	initial retire = '0;
	// one edge per call; idle calls leave stale fields scrambled
	task automatic send(input perb_pkg::perb_retire_s r);
		@(posedge mclk);
		retire <= r.valid ? r : {1'b0, ~retire[314:0]};
	endtask
endmodule

// File: src/perb_builder.sv
// event record builder for value samples, retirements and branches
`include "perb_consts.svh"
module perb_builder (
	input wire logic mclk,
	input wire logic srst,
	input wire perb_pkg::perb_retire_s retire,
	input wire logic [7:0] core_tag,
	input wire logic timestamp_enable_flag,
	input wire logic [63:0] perf_timestamp_counter,
	input wire logic load_value_cnt,
	input wire logic load_instr_cnt,
	input wire logic load_branch_cnt,
	input wire logic [31:0] load_value,
	output perb_pkg::perb_record_s record,
	output logic record_valid
);
	perb_pkg::perb_retire_s held;
	logic [1:0] dec_value;
	logic [1:0] dec_instr;
	logic [1:0] dec_branch;
	logic ovf_value;
	logic ovf_instr;
	logic ovf_branch;
	logic user_ok;
	logic [7:0] core_tag_q;
	logic ts_en_q;
	logic [63:0] ts_q;

	////////////////////////////////////////////////////////////////////////
	// qualification of retirements
	// user level only
	assign user_ok = retire.valid && retire.user_whole && !retire.enters_user;
	assign dec_value = (retire.valid && retire.is_value_sample) ? 2'h1 : 2'h0;
	// all user instructions, fused counts two
	assign dec_instr = !user_ok ? 2'h0 : (retire.fused ? 2'h2 : 2'h1);
	assign dec_branch = (retire.valid && retire.is_branch &&
		!retire.is_far_or_system) ? 2'h1 : 2'h0;

	////////////////////////////////////////////////////////////////////////
	// three event counters
	perb_counter u_value_cnt (
		.mclk(mclk),
		.srst(srst),
		.load(load_value_cnt),
		.load_value(load_value),
		.dec(dec_value),
		.overflow(ovf_value)
	);
	perb_counter u_instr_cnt (
		.mclk(mclk),
		.srst(srst),
		.load(load_instr_cnt),
		.load_value(load_value),
		.dec(dec_instr),
		.overflow(ovf_instr)
	);
	perb_counter u_branch_cnt (
		.mclk(mclk),
		.srst(srst),
		.load(load_branch_cnt),
		.load_value(load_value),
		.dec(dec_branch),
		.overflow(ovf_branch)
	);

	////////////////////////////////////////////////////////////////////////
	// retirement and context held one cycle to meet the overflow flags
	always_ff @(posedge mclk) begin
		if (srst) begin
			held <= '0;
			core_tag_q <= 8'h00;
			ts_en_q <= 1'b0;
			ts_q <= 64'h0;
		end else begin
			held <= retire;
			core_tag_q <= core_tag;
			ts_en_q <= timestamp_enable_flag;
			ts_q <= perf_timestamp_counter;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// record assembly; priority value sample, then branch, then retired
	always_ff @(posedge mclk) begin
		if (srst) begin
			record <= '0;
			record_valid <= 1'b0;
		end else begin
			record_valid <= ovf_value || ovf_instr || ovf_branch;
			record <= '0;
			record.core_tag <= core_tag_q;
			record.timestamp <= ts_en_q ? ts_q : 64'h0;
			if (ovf_value) begin
				record.event_type_code <= `PERB_EVT_VALUE;
				record.flags <= held.imm;
				record.data1 <= held.rm_value;
				record.addr <= held.instr_addr;
				record.data2 <= held.legacy_mode ?
					{32'h0, held.reg_value[31:0]} : held.reg_value;
			end else if (ovf_branch) begin
				record.event_type_code <= `PERB_EVT_BRANCH;
				record.addr <= held.fused ? held.cond_addr : held.instr_addr;
				record.flags[8+`PERB_BIT_FUSED] <= held.fused;
				record.flags[8+`PERB_BIT_PRED_VALID] <= held.pred_valid;
				record.flags[8+`PERB_BIT_PRED_OK] <= held.pred_valid &&
					(held.pred_ok || held.unconditional);
				record.flags[8+`PERB_BIT_TAKEN] <= held.taken ||
					held.unconditional;
				record.data2 <= held.next_addr;
			end else if (ovf_instr) begin
				record.event_type_code <= `PERB_EVT_INSTR;
				record.addr <= held.fused ? held.cond_addr : held.instr_addr;
			end
		end
	end
endmodule

// File: src/perb_consts.svh
// constants for the profiling event record builder
`ifndef PERB_CONSTS_SVH
`define PERB_CONSTS_SVH
`define PERB_EVT_VALUE 8'h01
`define PERB_EVT_INSTR 8'h02
`define PERB_EVT_BRANCH 8'h03
`define PERB_BIT_FUSED 4
`define PERB_BIT_PRED_VALID 5
`define PERB_BIT_PRED_OK 6
`define PERB_BIT_TAKEN 7
`define PERB_CNT_W 32
`define PERB_CNT_RESET 32'h0000_0000
`endif

// File: src/perb_counter.sv
// down counter that flags when it goes negative
`include "perb_consts.svh"
module perb_counter (
	input wire logic mclk,
	input wire logic srst,
	input wire logic load,
	input wire logic [31:0] load_value,
	input wire logic [1:0] dec,
	output logic overflow
);
	logic [31:0] count;
	logic [32:0] diff;
	assign diff = {1'b0, count} - {31'h0, dec};
	// decrement and detect the step below zero
	always_ff @(posedge mclk) begin
		if (srst) begin
			count <= `PERB_CNT_RESET;
			overflow <= 1'b0;
		end else if (load) begin
			count <= load_value;
			overflow <= 1'b0;
		end else begin
			count <= diff[31:0];
			overflow <= (dec != 2'h0) && !count[31] && diff[31];
		end
	end
endmodule

// File: src/perb_pkg.sv
// types shared by the profiling event record builder
package perb_pkg;
	// one retirement event from the pipeline
	typedef struct packed {
		logic valid;
		logic user_whole;
		logic enters_user;
		logic is_value_sample;
		logic is_branch;
		logic is_far_or_system;
		logic fused;
		logic taken;
		logic unconditional;
		logic pred_valid;
		logic pred_ok;
		logic legacy_mode;
		logic [63:0] instr_addr;
		logic [63:0] cond_addr;
		logic [63:0] next_addr;
		logic [15:0] imm;
		logic [31:0] rm_value;
		logic [63:0] reg_value;
	} perb_retire_s;
	// one complete 32-byte record
	typedef struct packed {
		logic [63:0] timestamp;
		logic [63:0] data2;
		logic [63:0] addr;
		logic [31:0] data1;
		logic [15:0] flags;
		logic [7:0] core_tag;
		logic [7:0] event_type_code;
	} perb_record_s;
	typedef enum logic [2:0] {
		PERB_NONE = 3'b001,
		PERB_PEND = 3'b010,
		PERB_HOLD = 3'b100
	} perb_state_e;
endpackage
